// File: logic/tsc_regs.vh
// Register offsets, field positions, reset values and command codes of the touch sensor register bank.
`ifndef TSC_REGS_VH
`define TSC_REGS_VH

// =====================================================================
// Register selectors
`define TSC_SEL_SETUP   2'h0
`define TSC_SEL_STATE   2'h1
`define TSC_SEL_CLOCK   2'h2
`define TSC_SEL_MASK    2'h3

// =====================================================================
// Setup register fields
`define TSC_ROLE_HI     7
`define TSC_ROLE_LO     6
`define TSC_SWITCH_BIT  5
`define TSC_KEY_HI      4
`define TSC_KEY_LO      3
`define TSC_REGOFF_BIT  2
`define TSC_IRQM_BIT    1
`define TSC_MPWR_BIT    0

// =====================================================================
// Field encodings
`define TSC_ROLE_ALONE  2'h0
`define TSC_ROLE_SEC    2'h1
`define TSC_ROLE_PRI    2'h2
`define TSC_KEY_ALL     2'h0
`define TSC_KEY_TWO     2'h1
`define TSC_KEY_ONE     2'h2

// =====================================================================
// Clock register fields
`define TSC_CLKOUT_BIT  7
`define TSC_CLKIN_BIT   6

// =====================================================================
// Reset values
`define TSC_SETUP_RST   8'h00
`define TSC_STATE_RST   8'h00
`define TSC_CLOCK_RST   8'h0c
`define TSC_MASK_RST    8'hff

// =====================================================================
// Command codes
`define TSC_CMD_SRESET  8'h00
`define TSC_CMD_CLRINT  8'h03
`define TSC_CMD_WRCFG   8'h30
`define TSC_CMD_RDCFG   8'h33
`define TSC_CMD_WRCLK   8'h35
`define TSC_CMD_RDCLK   8'h36
`define TSC_CMD_WRMSK   8'h39
`define TSC_CMD_RDMSK   8'h3a

`endif

// File: logic/tsc_mode_dec.v
// Decoder of the setup register into role, clocking and power controls.
`timescale 1ns/1ps
`include "tsc_regs.vh"

module tsc_mode_dec (
  input  wire [7:0] setup_i,
  input  wire [7:0] clock_i,
  output reg        osc_enable_o,
  output reg        clk_out_enable_o,
  output reg        clk_in_enable_o,
  output wire       switch_behavior_o,
  output reg  [1:0] key_count_mode_o,
  output wire       regulator_off_o,
  output wire       irq_press_only_o,
  output wire       masked_channel_power_o
);

  reg [1:0] operation_role;

  // =====================================================================
  // Role decode; code 11 falls back to stand-alone.
  always @* begin
    operation_role = setup_i[`TSC_ROLE_HI:`TSC_ROLE_LO];
    case (operation_role)
      `TSC_ROLE_PRI: begin
        osc_enable_o     = 1'b1;
        clk_out_enable_o = 1'b1;
        clk_in_enable_o  = 1'b0;
      end
      `TSC_ROLE_SEC: begin
        osc_enable_o     = 1'b0;
        clk_out_enable_o = 1'b0;
        clk_in_enable_o  = 1'b1;
      end
      default: begin
        // Stand-alone (and unused 11): clock pins follow the clock register.
        clk_out_enable_o = clock_i[`TSC_CLKOUT_BIT];
        clk_in_enable_o  = clock_i[`TSC_CLKIN_BIT];
        osc_enable_o     = ~clock_i[`TSC_CLKIN_BIT];
      end
    endcase
  end

  // =====================================================================
  // Key mode decode; code 11 behaves as all keys.
  always @* begin
    case (setup_i[`TSC_KEY_HI:`TSC_KEY_LO])
      `TSC_KEY_TWO: key_count_mode_o = `TSC_KEY_TWO;
      `TSC_KEY_ONE: key_count_mode_o = `TSC_KEY_ONE;
      default:      key_count_mode_o = `TSC_KEY_ALL;
    endcase
  end

  // Single-bit controls.
  assign switch_behavior_o      = setup_i[`TSC_SWITCH_BIT];
  assign regulator_off_o        = setup_i[`TSC_REGOFF_BIT];
  assign irq_press_only_o       = setup_i[`TSC_IRQM_BIT];
  assign masked_channel_power_o = setup_i[`TSC_MPWR_BIT];

endmodule

// File: logic/tsc_state_upd.v
// Next-value logic of the touch state register under switching and key-count modes.
`timescale 1ns/1ps
`include "tsc_regs.vh"

module tsc_state_upd #(
  parameter CHANNELS = 8
) (
  input  wire [CHANNELS-1:0] state_i,
  input  wire [CHANNELS-1:0] active_i,
  input  wire                latching_i,
  input  wire [1:0]          key_mode_i,
  input  wire                state_read_i,
  output reg  [CHANNELS-1:0] state_o
);

  // Counts set bits of a vector.
  function [3:0] pop_count;
    input [CHANNELS-1:0] v;
    integer k;
    begin
      pop_count = 4'h0;
      for (k = 0; k < CHANNELS; k = k + 1) begin
        pop_count = pop_count + {3'h0, v[k]};
      end
    end
  endfunction

  reg [CHANNELS-1:0] kept;
  reg [CHANNELS-1:0] newbits;
  reg [3:0]          limit;
  reg [3:0]          cnt;
  integer            n;

  // =====================================================================
  // Keep or clear existing bits, then admit new activations lowest channel first.
  always @* begin
    kept    = {CHANNELS{1'b0}};
    newbits = {CHANNELS{1'b0}};
    limit   = 4'h8;
    cnt     = 4'h0;
    if (latching_i) begin
      if (state_read_i) begin
        kept = state_i & active_i;
      end else begin
        kept = state_i;
      end
    end else begin
      kept = state_i & active_i;
    end
    case (key_mode_i)
      `TSC_KEY_ONE: limit = 4'h1;
      `TSC_KEY_TWO: limit = 4'h2;
      default:      limit = 4'h8;
    endcase
    cnt = pop_count(kept);
    // Channel n feeds bit n.
    for (n = 0; n < CHANNELS; n = n + 1) begin
      if (active_i[n] && !kept[n] && cnt < limit) begin
        newbits[n] = 1'b1;
        cnt        = cnt + 4'h1;
      end
    end
    state_o = kept | newbits;
  end

endmodule

// File: logic/tsc_reg_bank.v
// Top of the touch sensor register bank: setup, state, clock and mask registers with interrupt.
`timescale 1ns/1ps
`include "tsc_regs.vh"

module tsc_reg_bank #(
  parameter CHANNELS = 8
) (
  input  wire                sys_clk_i,
  input  wire                rst_b_i,
  input  wire [CHANNELS-1:0] channel_active_i,
  input  wire                cmd_valid_i,
  input  wire [7:0]          cmd_code_i,
  input  wire [7:0]          cmd_wdata_i,
  input  wire                state_read_i,
  output reg  [7:0]          rdata_o,
  output reg  [7:0]          touch_state_o,
  output reg  [7:0]          channel_enable_bits_o,
  output reg                 irq_b_o,
  output reg                 osc_enable_o,
  output reg                 clk_out_enable_o,
  output reg                 clk_in_enable_o,
  output reg                 regulator_off_o,
  output reg                 masked_channel_power_o
);

  // =====================================================================
  // Registers.
  reg [7:0]          device_setup_q;
  reg [7:0]          clock_setup_q;
  reg [7:0]          channel_mask_q;
  reg [CHANNELS-1:0] touch_flags_q;
  reg                irq_pend_q;

  wire               osc_en_w;
  wire               clko_w;
  wire               clki_w;
  wire               switch_behavior;
  wire [1:0]         key_count_mode;
  wire               regoff_w;
  wire               irq_press_only;
  wire               mpwr_w;
  wire [CHANNELS-1:0] touch_flags_d;
  reg                irq_event;
  reg  [7:0]         rdata_d;

  // Command strobes.
  wire cmd_sreset = cmd_valid_i && (cmd_code_i == `TSC_CMD_SRESET);
  wire cmd_clrint = cmd_valid_i && (cmd_code_i == `TSC_CMD_CLRINT);
  wire cmd_wrcfg  = cmd_valid_i && (cmd_code_i == `TSC_CMD_WRCFG);
  wire cmd_wrclk  = cmd_valid_i && (cmd_code_i == `TSC_CMD_WRCLK);
  wire cmd_wrmsk  = cmd_valid_i && (cmd_code_i == `TSC_CMD_WRMSK);

  // =====================================================================
  // Mode decode and state update.
  tsc_mode_dec u_dec (
    .setup_i                (device_setup_q),
    .clock_i                (clock_setup_q),
    .osc_enable_o           (osc_en_w),
    .clk_out_enable_o       (clko_w),
    .clk_in_enable_o        (clki_w),
    .switch_behavior_o      (switch_behavior),
    .key_count_mode_o       (key_count_mode),
    .regulator_off_o        (regoff_w),
    .irq_press_only_o       (irq_press_only),
    .masked_channel_power_o (mpwr_w)
  );

  tsc_state_upd #(
    .CHANNELS (CHANNELS)
  ) u_upd (
    .state_i      (touch_flags_q),
    .active_i     (channel_active_i),
    .latching_i   (switch_behavior),
    .key_mode_i   (key_count_mode),
    .state_read_i (state_read_i),
    .state_o      (touch_flags_d)
  );

  // Counts set bits of a state vector, so the two-key gate follows the channel parameter.
  function [3:0] set_count;
    input [CHANNELS-1:0] v;
    integer k;
    begin
      set_count = 4'h0;
      for (k = 0; k < CHANNELS; k = k + 1) begin
        set_count = set_count + {3'h0, v[k]};
      end
    end
  endfunction

  // =====================================================================
  // Interrupt event: sets count, clears only without press-only mode; two-key mode drops any event leaving fewer than two bits set.
  always @* begin
    if (irq_press_only) begin
      irq_event = |(touch_flags_d & ~touch_flags_q);
    end else begin
      irq_event = |(touch_flags_d ^ touch_flags_q);
    end
    if (key_count_mode == `TSC_KEY_TWO && set_count(touch_flags_d) < 4'h2) begin
      irq_event = 1'b0;
    end
  end

  // Read data mux for the read commands.
  always @* begin
    case (cmd_code_i)
      `TSC_CMD_RDCFG: rdata_d = device_setup_q;
      `TSC_CMD_RDCLK: rdata_d = clock_setup_q;
      `TSC_CMD_RDMSK: rdata_d = channel_mask_q;
      default:        rdata_d = rdata_o;
    endcase
    if (state_read_i) begin
      rdata_d = touch_flags_q;
    end else if (!cmd_valid_i) begin
      rdata_d = rdata_o;
    end
  end

  // =====================================================================
  // Register updates; reset and soft reset restore defaults.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i || cmd_sreset) begin
      device_setup_q <= `TSC_SETUP_RST;
      clock_setup_q  <= `TSC_CLOCK_RST;
      channel_mask_q <= `TSC_MASK_RST;
      touch_flags_q  <= `TSC_STATE_RST;
      irq_pend_q     <= 1'b0;
      rdata_o        <= 8'h00;
    end else begin
      if (cmd_wrcfg) begin
        device_setup_q <= cmd_wdata_i;
      end
      if (cmd_wrclk) begin
        clock_setup_q <= cmd_wdata_i;
      end
      if (cmd_wrmsk) begin
        channel_mask_q <= cmd_wdata_i;
      end
      touch_flags_q <= touch_flags_d;
      rdata_o       <= rdata_d;
      // A new event in the clearing cycle wins over the clear.
      if (irq_event) begin
        irq_pend_q <= 1'b1;
      end else if (state_read_i || cmd_clrint) begin
        irq_pend_q <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Registered outputs.
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      touch_state_o          <= 8'h00;
      channel_enable_bits_o  <= `TSC_MASK_RST;
      irq_b_o                <= 1'b1;
      osc_enable_o           <= 1'b1;
      clk_out_enable_o       <= 1'b0;
      clk_in_enable_o        <= 1'b0;
      regulator_off_o        <= 1'b0;
      masked_channel_power_o <= 1'b0;
    end else begin
      touch_state_o          <= touch_flags_q;
      channel_enable_bits_o  <= channel_mask_q;
      irq_b_o                <= ~irq_pend_q;
      osc_enable_o           <= osc_en_w;
      clk_out_enable_o       <= clko_w;
      clk_in_enable_o        <= clki_w;
      regulator_off_o        <= regoff_w;
      masked_channel_power_o <= mpwr_w;
    end
  end

endmodule

// File: test/tsc_reg_bank_assertions.sv
// Port assertions of the touch sensor register bank.
`timescale 1ns/1ps
module tsc_reg_bank_assertions #(
  parameter CHANNELS = 8
) (
  input wire                sys_clk_i,
  input wire                rst_b_i,
  input wire [CHANNELS-1:0] channel_active_i,
  input wire                cmd_valid_i,
  input wire [7:0]          cmd_code_i,
  input wire [7:0]          cmd_wdata_i,
  input wire                state_read_i,
  input wire [7:0]          rdata_o,
  input wire [7:0]          touch_state_o,
  input wire [7:0]          channel_enable_bits_o,
  input wire                irq_b_o,
  input wire                osc_enable_o,
  input wire                clk_out_enable_o,
  input wire                clk_in_enable_o,
  input wire                regulator_off_o,
  input wire                masked_channel_power_o
);
  // =====================================================================
  // Clocking and command sequences.
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_cmd(c);
    cmd_valid_i && cmd_code_i == c;
  endsequence
  sequence s_wr(c);
    s_cmd(c) ##1 !cmd_valid_i;
  endsequence
  // =====================================================================
  // Properties on the decoded outputs, state and interrupt.
  property p_primary;
    cmd_wdata_i[7:6] == 2'h2 ##0 s_wr(8'h30) |=> osc_enable_o && clk_out_enable_o && !clk_in_enable_o;
  endproperty
  property p_second;
    cmd_wdata_i[7:6] == 2'h1 ##0 s_wr(8'h30) |=> !osc_enable_o && !clk_out_enable_o && clk_in_enable_o;
  endproperty
  property p_power;
    s_wr(8'h30) |=> ($past(cmd_wdata_i, 2) & 8'h05) == {5'h0, regulator_off_o, 1'b0, masked_channel_power_o};
  endproperty
  property p_mask;
    s_wr(8'h39) |=> channel_enable_bits_o == $past(cmd_wdata_i, 2);
  endproperty
  property p_clr;
    s_cmd(8'h03) ##0 $stable(channel_active_i) && $past(channel_active_i) == $past(channel_active_i, 2)
      ##1 $stable(channel_active_i) |=> irq_b_o;
  endproperty
  property p_cause;
    $fell(irq_b_o) |-> touch_state_o != $past(touch_state_o);
  endproperty
  property p_set;
    (touch_state_o & ~$past(touch_state_o) & ~$past(channel_active_i, 2)) == 8'h00;
  endproperty
  property p_hold;
    !cmd_valid_i && !$past(cmd_valid_i) && !state_read_i |=> $stable(rdata_o);
  endproperty
  a_primary: assert property (p_primary) else $error("primary role controls wrong");
  a_second: assert property (p_second) else $error("secondary role controls wrong");
  a_power: assert property (p_power) else $error("regulator or masking power wrong");
  a_mask: assert property (p_mask) else $error("mask register not written");
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  a_cause: assert property (p_cause) else $error("interrupt without state change");
  a_set: assert property (p_set) else $error("state bit set without activation");
  a_hold: assert property (p_hold) else $error("read data changed without read");
endmodule

bind tsc_reg_bank tsc_reg_bank_assertions #(.CHANNELS(CHANNELS)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .channel_active_i(channel_active_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .state_read_i(state_read_i), .rdata_o(rdata_o),
  .touch_state_o(touch_state_o), .channel_enable_bits_o(channel_enable_bits_o), .irq_b_o(irq_b_o),
  .osc_enable_o(osc_enable_o), .clk_out_enable_o(clk_out_enable_o), .clk_in_enable_o(clk_in_enable_o),
  .regulator_off_o(regulator_off_o), .masked_channel_power_o(masked_channel_power_o));

// File: test/tsc_ctrl_model.sv
// Controller model that issues commands and state reads to the register bank.
`timescale 1ns/1ps
module tsc_ctrl_model (
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  output reg        cmd_valid_o,
  output reg  [7:0] cmd_code_o,
  output reg  [7:0] cmd_wdata_o,
  output reg        state_read_o
);
  // =====================================================================
  // Bus idles with no request pending.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 8'hff;
    cmd_wdata_o = 8'hff;
    state_read_o = 1'b0;
  end
  // One command or state read; the answer is taken after the outputs settle.
  task automatic xf(input logic st, input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
    begin
      @(posedge clk_i);
      #1;
      cmd_valid_o = ~st;
      state_read_o = st;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b0;
      state_read_o = 1'b0;
      cmd_code_o = ~c;
      cmd_wdata_o = ~d;
      repeat (2) @(posedge clk_i);
      #1;
      r = rdata_i;
    end
  endtask
endmodule

// File: test/tb_tsc_reg_bank.sv
// Self-checking testbench of the touch sensor register bank.
`timescale 1ns/1ps
module tb_tsc_reg_bank;
  reg         sys_clk_i;
  reg         rst_b_i;
  reg  [7:0]  act;
  reg  [7:0]  r;
  reg  [7:0]  v;
  reg  [31:0] tbl;
  wire        cv;
  wire        sr;
  wire [7:0]  cc;
  wire [7:0]  cw;
  wire [7:0]  rd;
  wire [7:0]  st;
  wire [7:0]  mk;
  wire        irq_b;
  wire [4:0]  ctl;
  integer     fails;
  integer     checks_done;
  integer     i;
  // =====================================================================
  // Register bank and controller model.
  tsc_reg_bank dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .channel_active_i(act), .cmd_valid_i(cv), .cmd_code_i(cc),
    .cmd_wdata_i(cw), .state_read_i(sr), .rdata_o(rd), .touch_state_o(st), .channel_enable_bits_o(mk),
    .irq_b_o(irq_b), .osc_enable_o(ctl[4]), .clk_out_enable_o(ctl[3]), .clk_in_enable_o(ctl[2]),
    .regulator_off_o(ctl[1]), .masked_channel_power_o(ctl[0]));
  tsc_ctrl_model u_ctl (
    .clk_i(sys_clk_i), .rdata_i(rd), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_wdata_o(cw), .state_read_o(sr));
  // Clock of 10 ns period.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // =====================================================================
  // Comparison, stimulus and closing tasks.
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task ci(input e);
    chk("irq", {7'h0, e}, {7'h0, irq_b});
  endtask
  task ch(input [7:0] a);
    begin
      @(posedge sys_clk_i);
      #1;
      act = a;
      repeat (3) @(posedge sys_clk_i);
      #1;
    end
  endtask
  task cmd(input [7:0] c, input [7:0] d);
    u_ctl.xf(1'b0, c, d, r);
  endtask
  // Code 01 stands for a state read; bit 5 of the clock register is ignored.
  task rc(input string n, input [7:0] c, input [7:0] e);
    begin
      u_ctl.xf(c == 8'h01, c, 8'h00, r);
      chk(n, e, r & ((c == 8'h36) ? 8'hdf : 8'hff));
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    #100000;
    fails = fails + 1;
    end_sim;
  end
  // =====================================================================
  // Test sequence.
  initial begin
    fails = 0;
    checks_done = 0;
    act = 8'h00;
    rst_b_i = 1'b0;
    tbl = 32'h3fc14480;
    repeat (16) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    rc("setup", 8'h33, 8'h00);
    rc("clock", 8'h36, 8'h0c);
    rc("mask", 8'h3a, 8'hff);
    rc("state", 8'h01, 8'h00);
    chk("clocking", 8'h10, {3'h0, ctl[4:2], 2'h0});
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      v = tbl[8*i +: 8];
      cmd(8'h30, v);
      rc("setup", 8'h33, v);
      chk("role", {3'h0, v[7:6] != 2'h1, v[7:6] == 2'h2, v[7:6] == 2'h1, 2'h0}, {3'h0, ctl[4:2], 2'h0});
      chk("power", {6'h0, v[2], v[0]}, {6'h0, ctl[1:0]});
    end
    $display("test setup done");
    cmd(8'h30, 8'h00);
    ch(8'h08);
    chk("state", 8'h08, st);
    ci(1'b0);
    rc("state", 8'h01, 8'h08);
    ci(1'b1);
    ch(8'h00);
    chk("state", 8'h00, st);
    ci(1'b0);
    cmd(8'h03, 8'h00);
    ci(1'b1);
    cmd(8'h30, 8'h02);
    ch(8'h01);
    ci(1'b0);
    rc("state", 8'h01, 8'h01);
    ch(8'h00);
    chk("state", 8'h00, st);
    ci(1'b1);
    $display("test direct done");
    cmd(8'h30, 8'h20);
    ch(8'h20);
    ch(8'h00);
    chk("state", 8'h20, st);
    ch(8'h02);
    rc("state", 8'h01, 8'h22);
    chk("state", 8'h02, st);
    ch(8'h00);
    rc("state", 8'h01, 8'h02);
    chk("state", 8'h00, st);
    $display("test latching done");
    cmd(8'h30, 8'h10);
    ch(8'h04);
    ch(8'h44);
    chk("state", 8'h04, st);
    ch(8'h00);
    cmd(8'h30, 8'h08);
    cmd(8'h03, 8'h00);
    ch(8'h02);
    chk("state", 8'h02, st);
    ci(1'b1);
    ch(8'h12);
    chk("state", 8'h12, st);
    ci(1'b0);
    ch(8'h92);
    chk("state", 8'h12, st);
    ch(8'h00);
    // The unused key code must let every activation through, like all-keys mode.
    cmd(8'h30, 8'h18);
    ch(8'h81);
    chk("state", 8'h81, st);
    ch(8'h00);
    $display("test key modes done");
    cmd(8'h39, 8'ha5);
    chk("mask", 8'ha5, mk);
    rc("mask", 8'h3a, 8'ha5);
    // In stand-alone role the clock pins follow the clock register.
    cmd(8'h35, 8'h4c);
    rc("clock", 8'h36, 8'h4c);
    chk("clocking", 8'h04, {3'h0, ctl[4:2], 2'h0});
    cmd(8'h00, 8'h00);
    rc("setup", 8'h33, 8'h00);
    rc("mask", 8'h3a, 8'hff);
    rc("clock", 8'h36, 8'h0c);
    chk("clocking", 8'h10, {3'h0, ctl[4:2], 2'h0});
    // Direct switching is back after the soft reset, so a release clears the bit.
    ch(8'h01);
    ch(8'h00);
    chk("state", 8'h00, st);
    $display("test soft reset done");
    end_sim;
  end
endmodule
